/* File: rtl/lcp_pkg.sv */
// Package for the cell protection monitor: register map, field positions, reset values, timing.
// Assumes a 40 MHz system clock and a byte-wide register port from the host interface logic.
package lcp_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS = 25;
  // Register byte addresses
  localparam logic [7:0] ADDR_PROT = 8'h00;
  localparam logic [7:0] ADDR_VOLT_MSB = 8'h0c;
  localparam logic [7:0] ADDR_VOLT_LSB = 8'h0d;
  localparam logic [7:0] ADDR_CUR_MSB = 8'h0e;
  localparam logic [7:0] ADDR_CUR_LSB = 8'h0f;
  localparam logic [7:0] ADDR_ACC_MSB = 8'h10;
  localparam logic [7:0] ADDR_ACC_LSB = 8'h11;
  localparam logic [7:0] ADDR_BIAS = 8'h33;
  // Protection register fields
  localparam int unsigned PB_OV = 7;
  localparam int unsigned PB_UV = 6;
  localparam int unsigned PB_COC = 5;
  localparam int unsigned PB_DOC = 4;
  localparam int unsigned PB_CC = 3;
  localparam int unsigned PB_DC = 2;
  localparam int unsigned PB_CE = 1;
  localparam int unsigned PB_DE = 0;
  localparam logic [7:0] BIAS_RESET = 8'h00;
  localparam logic CE_RESET = 1'b1;
  localparam logic DE_RESET = 1'b1;
  // Update periods and qualification delays
  localparam int unsigned VOLT_PERIOD_US = 3400;
  localparam int unsigned CUR_PERIOD_MS = 88;
  localparam int unsigned CUR_AVG_N = 128;
  localparam int unsigned VOLT_PERIOD_CYC = VOLT_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CUR_PERIOD_CYC = CUR_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned SAMPLE_CYC = CUR_PERIOD_CYC / CUR_AVG_N;
  localparam int unsigned OVD_DEFAULT_US = 1000;
  localparam int unsigned UVD_DEFAULT_US = 100000;
  localparam int unsigned OCD_DEFAULT_US = 8000;
  localparam int unsigned SCD_DEFAULT_US = 100;
  localparam int unsigned OVD_CYC = OVD_DEFAULT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned UVD_CYC = UVD_DEFAULT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned OCD_CYC = OCD_DEFAULT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SCD_CYC = SCD_DEFAULT_US * (CLK_HZ / 1_000_000);
  // Overvoltage early release at sense value of -2 mV, 15.625 uV per step
  localparam logic signed [11:0] OV_RELEASE_CODE = -12'sd128;
  localparam logic signed [11:0] CUR_MAX = 12'sh7ff;
  localparam logic signed [11:0] CUR_MIN = -12'sh800;
  localparam logic [10:0] VOLT_MAX = 11'h3ff;
  typedef enum logic [1:0] {LCP_ACTIVE = 2'b00, LCP_SLEEP = 2'b01} lcp_mode_t;
endpackage : lcp_pkg

/* File: rtl/lcp_monitor.sv */
// Cell protection monitor: fault qualification, sticky flags, FET controls, measurement registers.
// Assumes comparator and ADC inputs are synchronous to sys_clk_i, and the host register port is
// a single-cycle byte read/write strobe interface.
`timescale 1ns/1ps
module lcp_monitor import lcp_pkg::*; #(
  parameter int unsigned OVD_CYCLES = OVD_CYC,
  parameter int unsigned UVD_CYCLES = UVD_CYC,
  parameter int unsigned OCD_CYCLES = OCD_CYC,
  parameter int unsigned SCD_CYCLES = SCD_CYC,
  parameter int unsigned VOLT_CYCLES = VOLT_PERIOD_CYC,
  parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC,
  parameter logic INTERNAL_RES = 1'b0
) (
  input wire logic sys_clk_i, // 40 MHz clock
  input wire logic nrst_i, // Async reset, active low
  input wire logic cell_over_i, // Cell above overvoltage threshold
  input wire logic cell_below_ce_i, // Cell below charge-enable threshold
  input wire logic cell_under_i, // Cell below undervoltage threshold
  input wire logic supply_ok_i, // Supply above 2.2V
  input wire logic charger_present_i, // Pack terminal above supply
  input wire logic oc_pos_i, // Filtered sense above +overcurrent threshold
  input wire logic oc_neg_i, // Filtered sense below -overcurrent threshold
  input wire logic short_i, // Unfiltered sense node above short threshold
  input wire logic pack_low_i, // Pack terminal below supply minus trip margin
  input wire logic pack_high_i, // Pack terminal above supply minus trip margin
  input wire logic wake_i, // Other wake source (power switch, host)
  input wire logic signed [11:0] sense_sample_i, // Differential sense conversion
  input wire logic sense_valid_i, // Conversion strobe
  input wire logic [15:0] gain_comp_i, // Resistor compensation gain, 1.15 unsigned
  input wire logic [10:0] volt_sample_i, // Cell voltage conversion, unsigned
  input wire logic [7:0] reg_addr_i, // Register byte address
  input wire logic [7:0] reg_wdata_i, // Write data
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  output logic [7:0] reg_rdata_o, // Read data, valid cycle after strobe
  output logic charge_path_off_o, // Charge FET off, active high
  output logic discharge_path_off_o, // Discharge FET off, active high
  output logic pulldown_en_o, // Pack pulldown test current enable
  output logic pullup_en_o, // Pack pullup test current enable
  output logic sleep_o // Sleep mode
);
  // Refuse counts that the period and delay counters cannot serve
  if (SAMPLE_CYCLES < 1 || VOLT_CYCLES < 1 || OVD_CYCLES < 1 || UVD_CYCLES < 1 ||
      OCD_CYCLES < 1 || SCD_CYCLES < 1) begin : g_bad_count
    $error("lcp_monitor: counts must be at least one");
  end

  // Qualification delays: one counter per fault; both overcurrent comparators share one
  localparam int unsigned NQ = 4;
  localparam int unsigned QW = 32;
  logic [NQ-1:0] cond;
  logic [NQ-1:0] qual;
  assign cond = {short_i, oc_neg_i | oc_pos_i, cell_under_i, cell_over_i};
  genvar gi;
  generate
    for (gi = 0; gi < NQ; gi++) begin : g_qual
      localparam int unsigned LIM = (gi == 0) ? OVD_CYCLES : (gi == 1) ? UVD_CYCLES :
                                    (gi == 2) ? OCD_CYCLES : SCD_CYCLES;
      logic [QW-1:0] cnt_reg;
      logic [QW-1:0] cnt_next;
      always_comb begin
        cnt_next = '0;
        if (cond[gi] && cnt_reg < QW'(LIM)) begin
          cnt_next = cnt_reg + 32'd1;
        end else if (cond[gi]) begin
          cnt_next = cnt_reg;
        end
      end
      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          cnt_reg <= '0;
        end else begin
          cnt_reg <= cnt_next;
        end
      end
      assign qual[gi] = cond[gi] && cnt_reg >= QW'(LIM);
    end
  endgenerate

  // Protection state: sticky flags, active conditions, enables, sleep
  logic ov_flag_reg, uv_flag_reg, coc_flag_reg, doc_flag_reg;
  logic ov_flag_next, uv_flag_next, coc_flag_next, doc_flag_next;
  logic ov_act_reg, coc_act_reg, doc_act_reg;
  logic ov_act_next, coc_act_next, doc_act_next;
  logic ce_reg, de_reg, ce_next, de_next;
  lcp_mode_t mode_reg, mode_next;
  logic cc_next, dc_next, pd_next, pu_next;
  logic prot_wr;
  logic signed [11:0] cur_reg;
  assign prot_wr = reg_wr_i && reg_addr_i == ADDR_PROT;

  always_comb begin
    ov_act_next = ov_act_reg;
    coc_act_next = coc_act_reg;
    doc_act_next = doc_act_reg;
    mode_next = mode_reg;
    ce_next = prot_wr ? reg_wdata_i[PB_CE] : ce_reg;
    de_next = prot_wr ? reg_wdata_i[PB_DE] : de_reg;
    // Host writes 0 to clear a flag; a new event in the same cycle wins
    ov_flag_next = (ov_flag_reg & ~(prot_wr & ~reg_wdata_i[PB_OV]));
    uv_flag_next = (uv_flag_reg & ~(prot_wr & ~reg_wdata_i[PB_UV]));
    coc_flag_next = (coc_flag_reg & ~(prot_wr & ~reg_wdata_i[PB_COC]));
    doc_flag_next = (doc_flag_reg & ~(prot_wr & ~reg_wdata_i[PB_DOC]));
    if (mode_reg == LCP_ACTIVE) begin
      if (qual[0]) begin
        ov_act_next = 1'b1;
        ov_flag_next = 1'b1;
      end else if (ov_act_reg && (cell_below_ce_i || cur_reg <= OV_RELEASE_CODE)) begin
        ov_act_next = 1'b0;
      end
      if (qual[2] && oc_pos_i) begin
        coc_act_next = 1'b1;
        coc_flag_next = 1'b1;
      end else if (coc_act_reg && pack_low_i) begin
        coc_act_next = 1'b0;
      end
      if ((qual[2] && oc_neg_i) || qual[3]) begin
        doc_act_next = 1'b1;
        doc_flag_next = 1'b1;
      end else if (doc_act_reg && pack_high_i) begin
        doc_act_next = 1'b0;
      end
      if (qual[1]) begin
        uv_flag_next = 1'b1;
        mode_next = LCP_SLEEP;
      end
    end else if (supply_ok_i && (charger_present_i || wake_i)) begin
      // Every wake source waits for a healthy supply, so a flat cell is not loaded early
      mode_next = LCP_ACTIVE;
      ce_next = 1'b1;
      de_next = 1'b1;
      ov_act_next = 1'b0;
      coc_act_next = 1'b0;
      doc_act_next = 1'b0;
    end
    // Sleep covers undervoltage shutdown of both paths
    dc_next = (mode_next == LCP_SLEEP) | coc_act_next | doc_act_next | ~de_next;
    cc_next = (mode_next == LCP_SLEEP) | ov_act_next | coc_act_next | ~ce_next;
    pd_next = coc_act_next && mode_next == LCP_ACTIVE;
    pu_next = doc_act_next && mode_next == LCP_ACTIVE;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ov_flag_reg <= 1'b0;
      uv_flag_reg <= 1'b0;
      coc_flag_reg <= 1'b0;
      doc_flag_reg <= 1'b0;
      ov_act_reg <= 1'b0;
      coc_act_reg <= 1'b0;
      doc_act_reg <= 1'b0;
      ce_reg <= CE_RESET;
      de_reg <= DE_RESET;
      mode_reg <= LCP_ACTIVE;
      charge_path_off_o <= ~CE_RESET;
      discharge_path_off_o <= ~DE_RESET;
      pulldown_en_o <= 1'b0;
      pullup_en_o <= 1'b0;
      sleep_o <= 1'b0;
    end else begin
      ov_flag_reg <= ov_flag_next;
      uv_flag_reg <= uv_flag_next;
      coc_flag_reg <= coc_flag_next;
      doc_flag_reg <= doc_flag_next;
      ov_act_reg <= ov_act_next;
      coc_act_reg <= coc_act_next;
      doc_act_reg <= doc_act_next;
      ce_reg <= ce_next;
      de_reg <= de_next;
      mode_reg <= mode_next;
      charge_path_off_o <= cc_next;
      discharge_path_off_o <= dc_next;
      pulldown_en_o <= pd_next;
      pullup_en_o <= pu_next;
      sleep_o <= (mode_next == LCP_SLEEP);
    end
  end

  // Measurement path: bias, compensation, 128-average, saturation, accumulator
  logic [7:0] bias_reg, bias_next;
  logic signed [18:0] sum_reg, sum_next;
  logic [6:0] n_reg, n_next;
  logic signed [11:0] cur_next;
  logic signed [23:0] acc_reg, acc_next;
  logic [10:0] volt_reg, volt_next;
  logic [31:0] vcnt_reg, vcnt_next;
  logic signed [12:0] corr;
  logic signed [29:0] scaled;
  logic [7:0] acc_lsb_hold_reg, acc_lsb_hold_next;

  // Clamp to the signed 12-bit range instead of wrapping
  function automatic logic signed [11:0] sat12(input logic signed [12:0] v);
    if (v > 13'(CUR_MAX)) begin
      return CUR_MAX;
    end else if (v < 13'(CUR_MIN)) begin
      return CUR_MIN;
    end
    return v[11:0];
  endfunction : sat12

  always_comb begin
    corr = 13'(sense_sample_i) - 13'(signed'(bias_reg));
    // Internal resistor: scale to 0.625 mA units with trimmed gain
    scaled = 30'(corr) * $signed({1'b0, gain_comp_i});
    sum_next = sum_reg;
    n_next = n_reg;
    cur_next = cur_reg;
    acc_next = acc_reg;
    if (sense_valid_i && mode_reg == LCP_ACTIVE) begin
      // Positive sense adds, negative subtracts, for average and accumulator
      sum_next = sum_reg + 19'(INTERNAL_RES ? sat12(13'(scaled >>> 15)) : sat12(corr));
      n_next = n_reg + 7'd1;
      if (n_reg == 7'h7f) begin
        cur_next = sat12(13'((sum_next) >>> 7));
        sum_next = '0;
        // Add the fresh average itself; the running sum has just been cleared
        acc_next = acc_reg + 24'(cur_next);
      end
    end
    if (reg_wr_i && reg_addr_i == ADDR_ACC_MSB) begin
      acc_next = {reg_wdata_i, acc_lsb_hold_reg, 8'h00};
    end
    acc_lsb_hold_next = (reg_wr_i && reg_addr_i == ADDR_ACC_LSB) ? reg_wdata_i : acc_lsb_hold_reg;
    bias_next = (reg_wr_i && reg_addr_i == ADDR_BIAS) ? reg_wdata_i : bias_reg;
    vcnt_next = (vcnt_reg >= VOLT_CYCLES - 1) ? '0 : vcnt_reg + 32'd1;
    volt_next = volt_reg;
    if (vcnt_reg >= VOLT_CYCLES - 1 && mode_reg == LCP_ACTIVE) begin
      volt_next = (volt_sample_i > VOLT_MAX) ? VOLT_MAX : volt_sample_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bias_reg <= BIAS_RESET;
      sum_reg <= '0;
      n_reg <= '0;
      cur_reg <= '0;
      acc_reg <= '0;
      acc_lsb_hold_reg <= '0;
      volt_reg <= '0;
      vcnt_reg <= '0;
    end else begin
      bias_reg <= bias_next;
      sum_reg <= sum_next;
      n_reg <= n_next;
      cur_reg <= cur_next;
      acc_reg <= acc_next;
      acc_lsb_hold_reg <= acc_lsb_hold_next;
      volt_reg <= volt_next;
      vcnt_reg <= vcnt_next;
    end
  end

  // Register read mux; unmapped addresses read zero
  logic [7:0] rd_next;
  logic [15:0] v16, c16;
  always_comb begin
    v16 = {volt_reg[9:0], 6'h00};
    c16 = {cur_reg, 4'h0};
    rd_next = 8'h00;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_PROT: rd_next = {ov_flag_reg, uv_flag_reg, coc_flag_reg, doc_flag_reg,
                              charge_path_off_o, discharge_path_off_o, ce_reg, de_reg};
        ADDR_VOLT_MSB: rd_next = v16[15:8];
        ADDR_VOLT_LSB: rd_next = v16[7:0];
        ADDR_CUR_MSB: rd_next = c16[15:8];
        ADDR_CUR_LSB: rd_next = c16[7:0];
        ADDR_ACC_MSB: rd_next = acc_reg[23:16];
        ADDR_ACC_LSB: rd_next = acc_reg[15:8];
        ADDR_BIAS: rd_next = bias_reg;
        default: rd_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= rd_next;
    end
  end
endmodule : lcp_monitor

/* File: dv/lcp_monitor_asserts.sv */
// Checker for the cell protection monitor: fault timing and output relations at the top ports.
// Assumes it is bound to every monitor instance and shares its delay parameters.
`timescale 1ns/1ps
module lcp_monitor_asserts import lcp_pkg::*; #(
  parameter int unsigned OVD_CYCLES = 4,
  parameter int unsigned UVD_CYCLES = 4,
  parameter int unsigned OCD_CYCLES = 4,
  parameter int unsigned SCD_CYCLES = 4
) (
  input wire logic sys_clk_i, // Clock
  input wire logic nrst_i, // Reset, active low
  input wire logic cell_over_i, // Over compare
  input wire logic cell_below_ce_i, // Below charge-enable
  input wire logic cell_under_i, // Under compare
  input wire logic charger_present_i, // Charger seen
  input wire logic oc_pos_i, // Charge overcurrent
  input wire logic oc_neg_i, // Discharge overcurrent
  input wire logic short_i, // Short compare
  input wire logic pack_high_i, // Pack pulled high
  input wire logic wake_i, // Wake source
  input wire logic [7:0] reg_addr_i, // Address
  input wire logic [7:0] reg_wdata_i, // Write data
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  input wire logic [7:0] reg_rdata_o, // Read data
  input wire logic charge_path_off_o, // Charge off
  input wire logic discharge_path_off_o, // Discharge off
  input wire logic sleep_o // Sleep
);
  // Conditions that must qualify; a release input cuts the run so a legal release never fires
  wire logic [4:0] hit = {short_i && !pack_high_i, oc_neg_i && !pack_high_i, oc_pos_i,
    cell_under_i && !wake_i && !charger_present_i, cell_over_i && !cell_below_ce_i};
  logic [15:0] c [5];
  // Run length of each condition, cleared when it drops
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 5; i++) begin
        c[i] <= 16'h0000;
      end
    end else begin
      // Saturate so a long hold never wraps back below the limits
      for (int i = 0; i < 5; i++) begin
        c[i] <= !hit[i] ? 16'h0000 : c[i] + 16'(c[i] != 16'hffff);
      end
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // Two cycles of margin past the edge that registers the qualified fault at the outputs
  chk_ov_charge_off: assert property (c[0] > OVD_CYCLES + 2 |-> charge_path_off_o)
    else $error("charge path on after overvoltage");
  chk_uv_shutdown: assert property (c[1] > UVD_CYCLES + 2 |->
    sleep_o && charge_path_off_o && discharge_path_off_o) else $error("no shutdown after undervoltage");
  chk_coc_both_off: assert property (c[2] > OCD_CYCLES + 2 |-> charge_path_off_o && discharge_path_off_o)
    else $error("paths on after charge overcurrent");
  chk_doc_dis_off: assert property (c[3] > OCD_CYCLES + 2 |-> discharge_path_off_o)
    else $error("discharge on after discharge overcurrent");
  chk_short_dis_off: assert property (c[4] > SCD_CYCLES + 2 |-> discharge_path_off_o)
    else $error("discharge on after short");
  chk_de_write_off: assert property (reg_wr_i && reg_addr_i == ADDR_PROT && !reg_wdata_i[PB_DE]
    |-> ##[1:2] discharge_path_off_o) else $error("discharge on with enable clear");
  chk_ce_write_off: assert property (reg_wr_i && reg_addr_i == ADDR_PROT && !reg_wdata_i[PB_CE]
    |-> ##[1:2] charge_path_off_o) else $error("charge on with enable clear");
  chk_sleep_both_off: assert property (sleep_o && $past(sleep_o) |->
    charge_path_off_o && discharge_path_off_o) else $error("path on during sleep");
  chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data without read");
  cov_ov: cover property (c[0] > OVD_CYCLES + 2);
  cov_sleep: cover property (sleep_o);
  cov_short: cover property (c[4] > SCD_CYCLES + 2);
endmodule : lcp_monitor_asserts
bind lcp_monitor lcp_monitor_asserts #(.OVD_CYCLES(OVD_CYCLES), .UVD_CYCLES(UVD_CYCLES), .OCD_CYCLES(OCD_CYCLES),
  .SCD_CYCLES(SCD_CYCLES)) u_chk (.sys_clk_i, .nrst_i, .cell_over_i, .cell_below_ce_i, .cell_under_i,
  .charger_present_i, .oc_pos_i, .oc_neg_i, .short_i, .pack_high_i, .wake_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .charge_path_off_o, .discharge_path_off_o, .sleep_o);

/* File: dv/lcp_pack_model.sv */
// Pack terminal model: discharge FET, test currents, charger and load as seen by the pack comparators.
// Assumes the bench switches charger and load; test currents come from the monitor.
`timescale 1ns/1ps
module lcp_pack_model (
  input wire logic discharge_off_i, // Discharge FET open
  input wire logic pulldown_i, // Pulldown test current
  input wire logic pullup_i, // Pullup test current
  input wire logic charger_on_i, // Charger attached
  input wire logic load_on_i, // Heavy load attached
  output logic pack_low_o, // Pack below supply minus margin
  output logic pack_high_o, // Pack above supply minus margin
  output logic charger_o // Pack above supply
);
  // A charger overrides the pulldown, so release waits for its removal
  assign pack_low_o = !charger_on_i && discharge_off_i && (pulldown_i || load_on_i);
  // The load holds the pack down against the pullup until it goes away
  assign pack_high_o = charger_on_i || (!load_on_i && (pullup_i || !discharge_off_i));
  assign charger_o = charger_on_i;
endmodule : lcp_pack_model

/* File: dv/lcp_monitor_bench.sv */
// Bench for the cell protection monitor: faults, releases, registers and measurements.
// Assumes checker and pack model are compiled first; short delay parameters keep the run brief.
`timescale 1ns/1ps
module lcp_monitor_bench import lcp_pkg::*;;
  localparam int OVD = 4, UVD = 6, OCD = 5, SCD = 3, VC = 20;
  logic clk = 0, nrst = 0, bce = 0, sup = 1, wake = 0, sv = 0, wr = 0, rd = 0, chg = 0, load = 0;
  logic [4:0] cond = '0;
  logic [11:0] samp = '0;
  logic [10:0] volt = '0;
  logic [7:0] addr = '0, wd = '0, rdata, b;
  logic [15:0] r;
  logic cpo, dpo, pd, pu, slp, plow, phigh, chgp;
  int err_count = 0, total_checks = 0, bias = 0, acc = 0, v, cur;
  int dl[5] = '{OVD, UVD, OCD, OCD, SCD};
  int fb[5] = '{7, 6, 5, 4, 4};
  logic [4:0] ex[5] = '{5'h10, 5'h19, 5'h1c, 5'h0a, 5'h0a};
  wire logic [4:0] outs = {cpo, dpo, pd, pu, slp};
  lcp_monitor #(.OVD_CYCLES(OVD), .UVD_CYCLES(UVD), .OCD_CYCLES(OCD), .SCD_CYCLES(SCD), .VOLT_CYCLES(VC)) uut (
    .sys_clk_i(clk), .nrst_i(nrst), .cell_over_i(cond[0]), .cell_below_ce_i(bce), .cell_under_i(cond[1]),
    .supply_ok_i(sup), .charger_present_i(chgp), .oc_pos_i(cond[2]), .oc_neg_i(cond[3]), .short_i(cond[4]),
    .pack_low_i(plow), .pack_high_i(phigh), .wake_i(wake), .sense_sample_i(samp), .sense_valid_i(sv),
    .gain_comp_i(16'h8000), .volt_sample_i(volt), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .charge_path_off_o(cpo), .discharge_path_off_o(dpo),
    .pulldown_en_o(pd), .pullup_en_o(pu), .sleep_o(slp));
  lcp_pack_model pack (.discharge_off_i(dpo), .pulldown_i(pd), .pullup_i(pu), .charger_on_i(chg),
    .load_on_i(load), .pack_low_o(plow), .pack_high_o(phigh), .charger_o(chgp));
  // 40 MHz clock
  always #12.5 clk = ~clk;
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  // Inputs always move 2 ns after the edge, clear of sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc
  // One strobed register access; read data is taken one cycle later
  task automatic bus(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    cyc(1);
    addr = a;
    wd = d;
    wr = w;
    rd = !w;
    cyc(1);
    q = rdata;
    wr = 0;
    rd = 0;
  endtask : bus
  task automatic rd16(input logic [7:0] a);
    bus(0, a, 8'h00, r[15:8]);
    bus(0, a + 8'h01, 8'h00, r[7:0]);
  endtask : rd16
  // 128 equal conversions, so the average is exact; model saturates after the bias
  task automatic meas(input int val);
    samp = 12'(val);
    repeat (128) begin
      sv = 1;
      cyc(1);
      sv = 0;
      cyc(1);
    end
    cyc(2);
    cur = val - bias;
    cur = cur > 2047 ? 2047 : (cur < -2048 ? -2048 : cur);
    acc += cur;
    rd16(ADDR_CUR_MSB);
    check("current", 16'(cur * 16), r);
    rd16(ADDR_ACC_MSB);
    check("accum", 16'(acc >>> 8), r);
  endtask : meas
  // Watchdog: a hang still ends in the verdict
  initial begin
    #1000000;
    err_count++;
    test_done();
  end
  // Main sequence
  initial begin
    v = $urandom(32'had93bab2);
    repeat (5) @(posedge clk);
    #2;
    nrst = 1;
    bus(0, ADDR_PROT, 8'h00, b);
    check("prot", 16'h0003, b);
    bus(0, ADDR_BIAS, 8'h00, b);
    check("bias", 16'h0000, b);
    bus(0, 8'h05, 8'h00, b);
    check("unmapped", 16'h0000, b);
    bus(1, ADDR_PROT, 8'h02, b);
    cyc(1);
    check("de clear", 16'h0008, outs);
    bus(1, ADDR_PROT, 8'h01, b);
    cyc(1);
    check("ce clear", 16'h0010, outs);
    bus(1, ADDR_PROT, 8'h03, b);
    for (int k = 0; k < 5; k++) begin
      chg = k == 2;
      load = k > 2;
      cond[k] = 1;
      cyc(dl[k]);
      cond[k] = 0;
      cyc(2);
      check("pulse", 16'h0000, outs);
      cond[k] = 1;
      cyc(dl[k] + 3);
      check("fault", ex[k], outs);
      cond[k] = 0;
      sup = k != 1;
      chg = k == 1 || k == 2;
      cyc(4);
      check("held", ex[k], outs);
      sup = 1;
      bce = k == 0;
      chg = k == 1;
      load = 0;
      cyc(4);
      check("release", 16'h0000, outs);
      bce = 0;
      chg = 0;
      bus(0, ADDR_PROT, 8'h00, b);
      check("flag", 16'(8'h03 | (8'h01 << fb[k])), b);
      bus(1, ADDR_PROT, 8'h03, b);
      bus(0, ADDR_PROT, 8'h00, b);
      check("cleared", 16'h0003, b);
    end
    cond[0] = 1;
    cyc(OVD + 3);
    check("ov set", 16'h0010, outs);
    cond[0] = 0;
    meas(-200);
    check("ov early", 16'h0000, outs);
    bus(1, ADDR_PROT, 8'h03, b);
    bus(1, ADDR_ACC_LSB, 8'h02, b);
    bus(1, ADDR_ACC_MSB, 8'h01, b);
    rd16(ADDR_ACC_MSB);
    check("accum write", 16'h0102, r);
    acc = 32'h10200;
    for (int i = 0; i < 5; i++) begin
      bias = i == 0 ? -16 : i == 1 ? 16 : int'($signed(8'($urandom)));
      v = i == 0 ? 2047 : i == 1 ? -2048 : int'($urandom_range(4095)) - 2048;
      bus(1, ADDR_BIAS, 8'(bias), b);
      meas(v);
    end
    bus(0, ADDR_BIAS, 8'h00, b);
    check("bias rw", 16'(8'(bias)), b);
    for (int i = 0; i < 2; i++) begin
      v = i == 0 ? int'($urandom_range(1023)) : 2047;
      volt = 11'(v);
      cyc(VC + 3);
      rd16(ADDR_VOLT_MSB);
      check("volt", 16'((v > 1023 ? 1023 : v) * 64), r);
    end
    test_done();
  end
endmodule : lcp_monitor_bench
